// ### logic/vpic_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Pending register shows every source's activity, masked or not
// - Readable register returns the number of the source in service
// - Core status register mirrors normal and fast request lines
// - Normal request comes from sources 1 to 31, redirected excluded
// - Each source has a 3-bit priority, 7 highest, 0 lowest
// - Request asserts on a condition; selection happens at vector read
// - Equal-priority ties go to the lowest source number
// - In service, only a higher priority reasserts the request
// - Vector read that selects pushes number and level on the stack
// - Nesting stack holds eight entries
// - Vector read returns the selected source's handler address
// - Vector register sits at offset matching system address F100
// - Vector read deasserts the request; software always reads it
// - Vector read clears an edge source's pending, not a level one
// - End-of-service pops the stack; higher pending reasserts request
// - Higher priority arriving during service reasserts the request
// - Redirected sources keep detection but never reach the resolver
// - Vector read never clears a redirected source
// - Mask set and cleared by bit-mask enable and disable commands, any number of bits per write
////////////////////////////////////////////////////////////////////////
module vpic_ctrl
  import vpic_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [AW-1:0]     address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Interrupt sources
  input  wire logic [NSRC-1:0]   src_in,
  // Processor request lines
  output logic                   normal_int_req_line_n,
  output logic                   fast_int_req_line_n
);

  vpic_state_t             st_r;
  vpic_state_t             st_nxt;
  vpic_pick_t              pick;
  vpic_frame_t             top;
  vpic_lvl_t               cur_lvl;
  vpic_num_t               cur_num;
  logic                    taken;
  logic                    vec_rd;
  logic                    eos_wr;
  logic                    in_svc;
  logic                    push_ok;
  logic [AW-1:0]           addr_w;
  logic [31:0]             wm;
  logic [31:0]             wbits;
  logic [31:0]             hvec_sel;
  logic [NSRC-1:0]         act;
  logic [NSRC-1:0]         act_prev;
  logic [NSRC-1:0]         is_edge;
  logic [NSRC-1:0]         edge_ev;
  logic [NSRC-1:0]         pending;
  logic [NSRC-1:0]         cand;
  logic [NSRC-1:0]         auto_clr;
  logic [NSRC-1:0]         beaten;
  logic [NSRC-1:0][2:0]    prio;

  ////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, side effects at the taking edge
  assign taken       = (read || write) && !st_r.ack;
  assign waitrequest = (read || write) && !st_r.ack;
  assign readdata    = st_r.rdata;
  assign addr_w      = {address[AW-1:2], 2'b00};

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wm[b*8 +: 8] = {8{byteenable[b]}};
    end
  end

  assign wbits  = writedata & wm;
  assign vec_rd = taken && read && addr_w == OFS_NVEC;
  assign eos_wr = taken && write && addr_w == OFS_EOS;

  ////////////////////////////////////////////////////////////////////
  // Source conditioning
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      prio[i]     = st_r.mode[i][PRIO_LSB +: 3];
      is_edge[i]  = st_r.mode[i][TRIG_EDG];
      act[i]      = st_r.s2[i] ^ st_r.mode[i][TRIG_INV];
      act_prev[i] = st_r.prev[i] ^ st_r.mode[i][TRIG_INV];
    end
  end

  assign edge_ev = act & ~act_prev & is_edge;

  assign pending = (is_edge & st_r.edge_lat) | (~is_edge & act);

  assign cand = pending & st_r.mask & ~st_r.redir
              & {{(NSRC-1){1'b1}}, 1'b0};

  vpic_resolve #(
    .N (NSRC)
  ) u_resolve (
    .cand (cand),
    .prio (prio),
    .pick (pick)
  );

  ////////////////////////////////////////////////////////////////////
  // Current level from the stack top
  assign in_svc  = st_r.depth != 4'd0;
  assign top     = st_r.stk[3'(st_r.depth - 4'd1)];
  assign cur_lvl = in_svc ? top.lvl : 3'h0;
  assign cur_num = in_svc ? top.num : 5'h00;

  assign push_ok = pick.valid
                && (!in_svc || pick.lvl > cur_lvl)
                && st_r.depth < 4'(STK_N);

  assign hvec_sel = st_r.hvec[pick.num];

  always_comb begin
    auto_clr = '0;
    if (vec_rd && push_ok && is_edge[pick.num]
        && !st_r.redir[pick.num]) begin
      auto_clr[pick.num] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = src_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;
    st_nxt.ack  = taken;

    st_nxt.edge_lat = is_edge & (edge_ev | (st_r.edge_lat & ~auto_clr));

    if (taken && write) begin
      if (addr_w[AW-1:7] == OFS_MODE[AW-1:7]) begin
        st_nxt.mode[addr_w[6:2]] = (st_r.mode[addr_w[6:2]] & ~wm[7:0])
                                 | (writedata[7:0] & wm[7:0]);
      end
      if (addr_w[AW-1:7] == OFS_HVEC[AW-1:7]) begin
        st_nxt.hvec[addr_w[6:2]] = (st_r.hvec[addr_w[6:2]] & ~wm)
                                 | (writedata & wm);
      end
      case (addr_w)
        OFS_MEN: begin
          st_nxt.mask = st_r.mask | wbits;
        end
        OFS_MDIS: begin
          st_nxt.mask = st_r.mask & ~wbits;
        end
        OFS_REN: begin
          st_nxt.redir = st_r.redir | wbits;
        end
        OFS_RDIS: begin
          st_nxt.redir = st_r.redir & ~wbits;
        end
        // Set beats clear for a same-cycle edge
        OFS_ECLR: begin
          st_nxt.edge_lat = is_edge
                          & (edge_ev | (st_r.edge_lat & ~wbits));
        end
        OFS_ESET: begin
          st_nxt.edge_lat = is_edge
                          & (edge_ev | wbits | st_r.edge_lat);
        end
        default: begin
        end
      endcase
    end

    if (eos_wr && in_svc) begin
      st_nxt.depth = st_r.depth - 4'd1;
    end

    if (taken && read) begin
      case (addr_w)
        OFS_PEND: begin
          st_nxt.rdata = pending;
        end
        OFS_MASK: begin
          st_nxt.rdata = st_r.mask;
        end
        OFS_CUR: begin
          st_nxt.rdata = {27'h0, cur_num};
        end
        OFS_CORE: begin
          st_nxt.rdata = '0;
          st_nxt.rdata[CORE_NRM] = !st_r.nreq_n;
          st_nxt.rdata[CORE_FST] = !st_r.freq_n;
        end
        OFS_RSTAT: begin
          st_nxt.rdata = st_r.redir;
        end
        OFS_NVEC: begin
          st_nxt.rdata = SPUR_VEC;
        end
        default: begin
          st_nxt.rdata = '0;
          if (addr_w[AW-1:7] == OFS_MODE[AW-1:7]) begin
            st_nxt.rdata = {24'h0, st_r.mode[addr_w[6:2]]};
          end
          if (addr_w[AW-1:7] == OFS_HVEC[AW-1:7]) begin
            st_nxt.rdata = st_r.hvec[addr_w[6:2]];
          end
        end
      endcase
    end

    if (vec_rd && push_ok) begin
      st_nxt.stk[st_r.depth[2:0]] = '{num: pick.num, lvl: pick.lvl};
      st_nxt.depth = st_r.depth + 4'd1;
      st_nxt.rdata = hvec_sel;
    end

    st_nxt.nreq_n = !push_ok;
    st_nxt.freq_n = !((pending[0] && st_r.mask[0])
                   || |(pending & st_r.mask & st_r.redir));
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign normal_int_req_line_n = st_r.nreq_n;
  assign fast_int_req_line_n   = st_r.freq_n;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      beaten[i] = pick.valid && cand[i]
               && (prio[i] > pick.lvl
                   || (prio[i] == pick.lvl && 5'(i) < pick.num));
    end
  end

  property p_pend_rd;
    taken && read && addr_w == OFS_PEND |=> readdata == $past(pending);
  endproperty
  a_pend_rd: assert property (p_pend_rd)
    else $error("pending readback wrong");

  property p_cur_rd;
    taken && read && addr_w == OFS_CUR |=> readdata[4:0] == $past(cur_num);
  endproperty
  a_cur_rd: assert property (p_cur_rd)
    else $error("current source readback wrong");

  property p_core_rd;
    taken && read && addr_w == OFS_CORE
      |=> readdata[1:0] == ~$past({fast_int_req_line_n,
                                   normal_int_req_line_n});
  endproperty
  a_core_rd: assert property (p_core_rd)
    else $error("core status wrong");

  property p_no_redir;
    pick.valid |-> !st_r.redir[pick.num] && pick.num != 5'h00;
  endproperty
  a_no_redir: assert property (p_no_redir)
    else $error("redirected or source 0 selected");

  property p_idle_req;
    !in_svc && pick.valid |=> !normal_int_req_line_n;
  endproperty
  a_idle_req: assert property (p_idle_req)
    else $error("request missing while idle");

  property p_tie;
    beaten == '0;
  endproperty
  a_tie: assert property (p_tie)
    else $error("winner outranked");

  property p_hold;
    in_svc && pick.valid && pick.lvl <= cur_lvl |=> normal_int_req_line_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request at or below current level");

  property p_push;
    vec_rd && push_ok
      |=> st_r.depth == $past(st_r.depth) + 4'd1
          && top.lvl == $past(pick.lvl);
  endproperty
  a_push: assert property (p_push)
    else $error("stack push wrong");

  property p_depth;
    st_r.depth <= 4'(STK_N);
  endproperty
  a_depth: assert property (p_depth)
    else $error("stack overflow");

  property p_vec;
    vec_rd && push_ok |=> readdata == $past(hvec_sel);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector data wrong");

  property p_drop;
    vec_rd && push_ok ##1 !push_ok |=> normal_int_req_line_n;
  endproperty
  a_drop: assert property (p_drop)
    else $error("request not dropped after vector read");

  property p_autoclr;
    vec_rd && push_ok && is_edge[pick.num] && !edge_ev[pick.num]
      |=> !st_r.edge_lat[$past(pick.num)];
  endproperty
  a_autoclr: assert property (p_autoclr)
    else $error("edge source not cleared");

  property p_pop;
    eos_wr && in_svc |=> st_r.depth == $past(st_r.depth) - 4'd1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop wrong");

  property p_redir_keep;
    vec_rd |=> ($past(st_r.edge_lat & st_r.redir) & ~st_r.edge_lat) == '0;
  endproperty
  a_redir_keep: assert property (p_redir_keep)
    else $error("redirected source cleared");

  property p_men;
    taken && write && addr_w == OFS_MEN
      |=> (st_r.mask & $past(wbits)) == $past(wbits);
  endproperty
  a_men: assert property (p_men)
    else $error("mask enable lost");

  property p_empty_eos;
    eos_wr && !in_svc |=> st_r.depth == 4'd0 && $stable(st_r.stk);
  endproperty
  a_empty_eos: assert property (p_empty_eos)
    else $error("empty pop changed state");

endmodule
`default_nettype wire

// ### logic/vpic_pkg.sv
`default_nettype none
package vpic_pkg;

  // Sizes
  localparam int NSRC  = 32;
  localparam int STK_N = 8;
  localparam int AW    = 9;

  // Byte offsets; the vector register sits where system address
  // 0xFFFFF100 lands in this window
  localparam logic [AW-1:0] OFS_MODE  = 9'h000;
  localparam logic [AW-1:0] OFS_HVEC  = 9'h080;
  localparam logic [AW-1:0] OFS_NVEC  = 9'h100;
  localparam logic [AW-1:0] OFS_CUR   = 9'h108;
  localparam logic [AW-1:0] OFS_PEND  = 9'h10c;
  localparam logic [AW-1:0] OFS_MASK  = 9'h110;
  localparam logic [AW-1:0] OFS_CORE  = 9'h114;
  localparam logic [AW-1:0] OFS_MEN   = 9'h120;
  localparam logic [AW-1:0] OFS_MDIS  = 9'h124;
  localparam logic [AW-1:0] OFS_ECLR  = 9'h128;
  localparam logic [AW-1:0] OFS_ESET  = 9'h12c;
  localparam logic [AW-1:0] OFS_EOS   = 9'h130;
  localparam logic [AW-1:0] OFS_REN   = 9'h140;
  localparam logic [AW-1:0] OFS_RDIS  = 9'h144;
  localparam logic [AW-1:0] OFS_RSTAT = 9'h148;

  // Source mode field layout
  localparam int PRIO_LSB = 0;
  localparam int TRIG_EDG = 5;
  localparam int TRIG_INV = 6;

  // Core status bits
  localparam int CORE_NRM = 0;
  localparam int CORE_FST = 1;

  // Reset and fixed values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [31:0] HVEC_RST = 32'h0000_0000;
  localparam logic [31:0] SPUR_VEC = 32'h0000_0000;

  typedef logic [2:0] vpic_lvl_t;
  typedef logic [4:0] vpic_num_t;

  typedef struct packed {
    vpic_num_t num;
    vpic_lvl_t lvl;
  } vpic_frame_t;

  typedef struct packed {
    logic      valid;
    vpic_num_t num;
    vpic_lvl_t lvl;
  } vpic_pick_t;

  typedef struct packed {
    logic [NSRC-1:0][7:0]     mode;
    logic [NSRC-1:0][31:0]    hvec;
    logic [NSRC-1:0]          mask;
    logic [NSRC-1:0]          redir;
    logic [NSRC-1:0]          edge_lat;
    logic [NSRC-1:0]          s1;
    logic [NSRC-1:0]          s2;
    logic [NSRC-1:0]          prev;
    vpic_frame_t [STK_N-1:0]  stk;
    logic [3:0]               depth;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     nreq_n;
    logic                     freq_n;
  } vpic_state_t;

  localparam vpic_state_t ST_RST = '{
    mode:   {NSRC{MODE_RST}},
    hvec:   {NSRC{HVEC_RST}},
    nreq_n: 1'b1,
    freq_n: 1'b1,
    default: '0
  };

endpackage
`default_nettype wire

// ### logic/vpic_resolve.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_resolve
  import vpic_pkg::*;
#(
  parameter int N = NSRC
) (
  // Candidates and their levels
  input  wire logic [N-1:0]        cand,
  input  wire logic [N-1:0][2:0]   prio,
  // Winner
  output vpic_pick_t               pick
);

  if (N < 2 || N > NSRC) begin : g_chk
    $error("vpic_resolve: N out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // Ascending scan: only a strictly higher level replaces the winner
  // lowest number wins
  always_comb begin
    pick = '0;
    for (int i = 1; i < N; i++) begin
      if (cand[i] && (!pick.valid || prio[i] > pick.lvl)) begin
        pick.valid = 1'b1;
        pick.num   = 5'(i);
        pick.lvl   = prio[i];
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/vpic_periph.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_periph
  import vpic_pkg::*;
(
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst,
  // Commands from the bench
  input  wire logic [NSRC-1:0] raise,
  input  wire logic [NSRC-1:0] lower,
  input  wire logic [NSRC-1:0] pulse,
  // Source lines
  output logic      [NSRC-1:0] src_in
);
  logic [NSRC-1:0] cond_r;
  logic [NSRC-1:0] pulse_r;

  ////////////////////////////////////////////////////////////////////////
  // held conditions and one-cycle pulses
  // A level condition stays up until the handler clears it here
  always_ff @(posedge clock) begin
    if (rst) begin
      cond_r  <= '0;
      pulse_r <= '0;
    end else begin
      cond_r  <= (cond_r | raise) & ~lower;
      pulse_r <= pulse;
    end
  end

  assign src_in = cond_r | pulse_r;
endmodule
`default_nettype wire

// ### verification/vpic_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_ctrl_bench
  import vpic_pkg::*;
();
  logic            clock;
  logic            rst;
  logic [AW-1:0]   address;
  logic            read;
  logic            write;
  logic [31:0]     writedata;
  logic [3:0]      byteenable;
  logic [31:0]     readdata;
  logic            waitrequest;
  logic [NSRC-1:0] src_in;
  logic [NSRC-1:0] raise;
  logic [NSRC-1:0] lower;
  logic [NSRC-1:0] pulse;
  logic            nreq_n;
  logic            freq_n;
  int              num_errors;
  int              checks;

  vpic_ctrl dut (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .src_in(src_in),
    .normal_int_req_line_n(nreq_n), .fast_int_req_line_n(freq_n));

  vpic_periph model (
    .clock(clock), .rst(rst), .raise(raise), .lower(lower),
    .pulse(pulse), .src_in(src_in));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      $display("BAD %s exp %h got %h", nm, ex, got);
      num_errors++;
    end
  endtask

  task automatic bus(input logic wr_en, input logic [AW-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    address   <= a;
    write     <= wr_en;
    read      <= !wr_en;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [AW-1:0] a,
                     input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, ex, q);
  endtask

  task automatic ctl(input logic [NSRC-1:0] r, input logic [NSRC-1:0] l,
                     input logic [NSRC-1:0] p);
    @(posedge clock);
    raise <= r;
    lower <= l;
    pulse <= p;
    @(posedge clock);
    raise <= '0;
    lower <= '0;
    pulse <= '0;
  endtask

  task automatic wait_line(input logic lv);
    int n;
    n = 0;
    while (nreq_n !== lv && n < 30) begin
      @(posedge clock);
      n++;
    end
    chk("req line", {31'h0, lv}, {31'h0, nreq_n});
    if (n == 30) give_verdict();
  endtask

  task automatic hold_high();
    repeat (8) begin
      @(posedge clock);
      chk("req line idle", 32'h1, {31'h0, nreq_n});
    end
  endtask

  function automatic logic [31:0] hv(input int n);
    return 32'hcafe_0000 + n;
  endfunction

  task automatic setup(input int n, input logic [7:0] md);
    wr(OFS_MODE + AW'(4 * n), {24'h0, md});
    wr(OFS_HVEC + AW'(4 * n), hv(n));
    wr(OFS_MEN, 32'h1 << n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc("pending", OFS_PEND, 32'h0);
    rdc("mask", OFS_MASK, 32'h0);
    rdc("core", OFS_CORE, 32'h0);
    rdc("unmapped", 9'h1fc, 32'h0);
  endtask

  task automatic t_prio();
    setup(3, 8'h02);
    setup(5, 8'h06);
    setup(9, 8'h06);
    wr(OFS_MODE + 9'h01c, 32'h07);
    ctl(32'h2a8, '0, '0);
    wait_line(1'b0);
    rdc("pending", OFS_PEND, 32'h2a8);
    rdc("core", OFS_CORE, 32'h1);
    rdc("vector", OFS_NVEC, hv(5));
    rdc("current", OFS_CUR, 32'h5);
    hold_high();
    ctl('0, 32'h20, '0);
    wr(OFS_EOS, 32'h0);
    wait_line(1'b0);
    rdc("vector", OFS_NVEC, hv(9));
    rdc("pending", OFS_PEND, 32'h288);
    ctl('0, 32'h288, '0);
    wr(OFS_EOS, 32'h0);
    hold_high();
  endtask

  task automatic t_nest();
    for (int i = 0; i < 8; i++) begin
      setup(10 + i, 8'h20 | 8'(i));
      ctl('0, '0, 32'h1 << (10 + i));
      wait_line(1'b0);
      rdc("vector", OFS_NVEC, hv(10 + i));
      rdc("current", OFS_CUR, 32'(10 + i));
    end
    rdc("pending", OFS_PEND, 32'h0);
    for (int i = 7; i >= 0; i--) begin
      rdc("stacked", OFS_CUR, 32'(10 + i));
      wr(OFS_EOS, 32'h0);
    end
    hold_high();
    wr(OFS_EOS, 32'h0);
    hold_high();
    rdc("current", OFS_CUR, 32'h0);
    rdc("mask", OFS_MASK, 32'h3fe28);
  endtask

  task automatic t_redir();
    setup(8, 8'h27);
    wr(OFS_REN, 32'h100);
    rdc("redir", OFS_RSTAT, 32'h100);
    ctl('0, '0, 32'h100);
    hold_high();
    chk("fast line", 32'h0, {31'h0, freq_n});
    rdc("core", OFS_CORE, 32'h2);
    rdc("spurious", OFS_NVEC, SPUR_VEC);
    rdc("pending", OFS_PEND, 32'h100);
    wr(OFS_RDIS, 32'h100);
    wait_line(1'b0);
    rdc("vector", OFS_NVEC, hv(8));
    rdc("pending", OFS_PEND, 32'h0);
    chk("fast line", 32'h1, {31'h0, freq_n});
    wr(OFS_EOS, 32'h0);
    wr(OFS_MDIS, 32'h100);
    ctl('0, '0, 32'h100);
    hold_high();
    rdc("pending", OFS_PEND, 32'h100);
    rdc("mask", OFS_MASK, 32'h3fe28);
    wr(OFS_ECLR, 32'h100);
    rdc("pending", OFS_PEND, 32'h0);
    wr(OFS_ESET, 32'h100);
    wr(OFS_MODE + 9'h050, 32'h40);
    rdc("pending", OFS_PEND, 32'h100100);
    rdc("mode", OFS_MODE + 9'h050, 32'h40);
    rdc("handler", OFS_HVEC + 9'h020, hv(8));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'hf;
    raise = '0;
    lower = '0;
    pulse = '0;
    num_errors = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_nest();
    t_redir();
    give_verdict();
  end
endmodule
`default_nettype wire
